// *** logic/dac_special_function_decoder.sv ***
/*
 * Special-function command decoder and 14-bit control register of a
 * 40-channel DAC, with register-select routing of incoming data words.
 * Assumes the host interface delivers one decoded word per cmd_valid pulse
 * on this clock, and that the pins are asynchronous to it.
 */
// Operation
// R1: Route words by two register-select bits.
// R2: Decode six command bits when select zero.
// R3: No-op changes nothing, busy still pulses.
// R4: Command one stores clear code, reset zero.
// R5: Clear pin or soft clear loads clear code.
// R6: Soft clear holds busy thirty-five microseconds.
// R7: Soft power-down keeps every register intact.
// R8: Power-down blocks all register writes.
// R9: Soft power-up ends within exit time.
// R10: Effective power-down ORs hardware and software.
// R11: Soft reset restores defaults, zeroes DACs.
// R12: Host avoids soft reset during power-down.
// R13: Control write or read by flag.
// R14: Bit thirteen sets power-down output load.
// R15: Bit twelve selects reference level.
// R16: Bit eleven enables amplifier boost.
// R17: Bit ten selects internal reference.
// R18: Bit nine routes monitor to last channel.
// R19: Bit eight enables thermal shutdown guard.
// R20: Bits seven, one, zero are ignored.
// R21: Bits six to two enable toggle groups.
// R22: Each toggle bit covers eight channels.
// R23: Monitor command takes channel, 63 three-states.
// R24: Gain codes decode to quarter factors.
// R25: Undefined command addresses act as no-op.
`timescale 1ns/100ps
module dac_special_function_decoder
	import sfr_decoder_pkg::*;
#(
	parameter int DATA_W = 14,
	parameter int CHANNELS = 40,
	parameter logic REF_LEVEL_DEFAULT = 1'b1,
	parameter int SOFT_CLEAR_LEN = SOFT_CLEAR_CYCLES,
	parameter int SOFT_RESET_LEN = SOFT_RESET_CYCLES,
	parameter int POWER_UP_LEN = POWER_UP_CYCLES
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Decoded host word.
	input wire logic cmd_valid,
	input wire logic register_select_high,
	input wire logic register_select_low,
	input wire logic read_not_write,
	input wire logic [5:0] command_address_bits,
	input wire logic [DATA_W-1:0] cmd_data,
	// Asynchronous pins.
	input wire logic clear_pin_n,
	input wire logic hw_power_down,
	input wire logic over_temperature,
	// Status and readback.
	output logic busy_n,
	output logic [DATA_W-1:0] readback_data,
	output logic readback_valid,
	// Data path strobes.
	output logic input_write,
	output logic offset_write,
	output logic gain_write,
	output logic [DATA_W-1:0] write_data,
	output logic [2:0] gain_quarters,
	output logic dac_clear_load,
	output logic dac_zero_load,
	output logic [DATA_W-1:0] clear_code,
	// Analog controls.
	output logic power_down,
	output logic amplifiers_on,
	output logic power_down_output_state,
	output logic reference_level_select,
	output logic amplifier_boost,
	output logic internal_reference_enable,
	output logic monitor_enable,
	output logic thermal_guard_enable,
	output logic [CHANNELS-1:0] toggle_enable,
	output logic [5:0] monitor_channel,
	output logic monitor_tristate
);
	// ====================================================
	// Helpers.

	// Decodes a gain code to a factor in quarters; four means unity.
	function automatic logic [2:0] gain_to_quarters(input logic [DATA_W-1:0] code);
		logic [2:0] q;
		q = 3'h0;
		// R24: gain factor decode
		if (code[3:0] == GAIN_TAIL && code[13:4] == {code[13:12], GAIN_MIDDLE[7:0]}) begin
			q = 3'({1'b0, code[13:12]}) + 3'h1;
		end
		return q;
	endfunction

	// ====================================================
	// Pin synchronisers: a change counts once stages two and three agree.
	logic [2:0] clear_sync_reg;
	logic [2:0] hwpd_sync_reg;
	logic [2:0] temp_sync_reg;
	logic clear_low_reg; // Filtered clear pin level (high means asserted).
	logic hwpd_reg; // Filtered hardware power-down level.
	logic hot_reg; // Filtered over-temperature level.

	// Shift the raw pins in; stage one only feeds stage two.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clear_sync_reg <= 3'h7;
			hwpd_sync_reg <= 3'h0;
			temp_sync_reg <= 3'h0;
		end else begin
			clear_sync_reg <= {clear_sync_reg[1:0], clear_pin_n};
			hwpd_sync_reg <= {hwpd_sync_reg[1:0], hw_power_down};
			temp_sync_reg <= {temp_sync_reg[1:0], over_temperature};
		end
	end

	// Accept a new level only when the two later stages agree.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clear_low_reg <= 1'b0;
			hwpd_reg <= 1'b0;
			hot_reg <= 1'b0;
		end else begin
			if (clear_sync_reg[1] == clear_sync_reg[2]) begin
				clear_low_reg <= ~clear_sync_reg[2];
			end
			if (hwpd_sync_reg[1] == hwpd_sync_reg[2]) begin
				hwpd_reg <= hwpd_sync_reg[2];
			end
			if (temp_sync_reg[1] == temp_sync_reg[2]) begin
				hot_reg <= temp_sync_reg[2];
			end
		end
	end

	// ====================================================
	// Command decode.
	logic [1:0] select; // Register select pair.
	logic idle; // No timed operation running.
	logic take; // A word is accepted this cycle.
	logic special; // Accepted word is a special function command.
	logic pd_eff; // Effective power-down state.
	logic sw_pd_reg; // Software power-down state.
	logic [13:0] control_reg; // Control register.
	logic [DATA_W-1:0] clear_code_reg; // Clear code register.
	logic [5:0] monitor_reg; // Monitored channel address.
	logic thermal_trip_reg; // Amplifiers shut down by the thermal guard.
	logic [11:0] busy_count_reg; // Remaining busy cycles.
	logic clear_prev_reg; // Clear pin level one cycle earlier.

	assign select = {register_select_high, register_select_low};
	// Words that arrive while busy are dropped; the host watches busy_n.
	assign idle = (busy_count_reg == 12'h000);
	assign take = cmd_valid && idle;
	// R2: special function select
	assign special = take && (select == SEL_SPECIAL);
	// R10: hardware OR software
	assign pd_eff = sw_pd_reg | hwpd_reg;

	// ====================================================
	// Busy timer. Every accepted word pulses busy for at least one cycle.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_count_reg <= 12'h000;
		end else if (take) begin
			busy_count_reg <= 12'h001;
			if (special && !read_not_write) begin
				case (command_address_bits)
					// R6: soft clear busy time
					CMD_SOFT_CLEAR: busy_count_reg <= 12'(SOFT_CLEAR_LEN);
					// R11: soft reset time
					CMD_SOFT_RESET: busy_count_reg <= 12'(SOFT_RESET_LEN);
					// R9: power-up exit time
					CMD_POWER_UP: busy_count_reg <= 12'(POWER_UP_LEN);
					default: busy_count_reg <= 12'h001;
				endcase
			end
		end else if (!idle) begin
			busy_count_reg <= busy_count_reg - 12'h001;
		end
	end

	// Busy output: low while the timer runs, registered.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_n <= 1'b1;
		end else begin
			// R3: busy pulses for no-op
			busy_n <= !(take || busy_count_reg > 12'h001);
		end
	end

	// ====================================================
	// Control register. Writes are blocked in power-down; soft reset
	// restores the defaults but is itself refused in power-down, since
	// the host is not meant to issue it then.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= CONTROL_RESET | (14'(REF_LEVEL_DEFAULT) << CTL_REF_LEVEL);
		end else if (special && !pd_eff && !read_not_write) begin
			// R8: write gating
			case (command_address_bits)
				// R13: control write
				CMD_CONTROL: control_reg <= cmd_data;
				// R11: restore defaults
				CMD_SOFT_RESET: control_reg <= CONTROL_RESET | (14'(REF_LEVEL_DEFAULT) << CTL_REF_LEVEL);
				// R25: others change nothing
				default: control_reg <= control_reg;
			endcase
		end
	end

	// Clear code and monitor address registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clear_code_reg <= CLEAR_CODE_RESET;
			monitor_reg <= MON_OFF_CHANNEL;
		end else if (special && !pd_eff && !read_not_write) begin
			case (command_address_bits)
				// R4: store clear code
				CMD_CLEAR_CODE: clear_code_reg <= cmd_data;
				// R23: monitor channel address
				CMD_MONITOR: monitor_reg <= cmd_data[MON_LO +: 6];
				CMD_SOFT_RESET: begin
					clear_code_reg <= CLEAR_CODE_RESET;
					monitor_reg <= MON_OFF_CHANNEL;
				end
				default: monitor_reg <= monitor_reg;
			endcase
		end
	end

	// Software power state and thermal shutdown. Power-up is honoured during
	// power-down, otherwise it could never end; so are power-down and soft clear.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sw_pd_reg <= 1'b0;
			thermal_trip_reg <= 1'b0;
		end else begin
			if (special && !read_not_write) begin
				case (command_address_bits)
					// R7: enter soft power-down
					CMD_POWER_DOWN: sw_pd_reg <= 1'b1;
					CMD_POWER_UP: sw_pd_reg <= 1'b0;
					default: sw_pd_reg <= sw_pd_reg;
				endcase
			end
			// R19: thermal guard
			if (control_reg[CTL_THERMAL] && hot_reg) begin
				thermal_trip_reg <= 1'b1;
			end else if (special && !read_not_write && command_address_bits == CMD_POWER_UP && !hot_reg) begin
				thermal_trip_reg <= 1'b0;
			end
		end
	end

	// ====================================================
	// Data path strobes routed by register select.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			input_write <= 1'b0;
			offset_write <= 1'b0;
			gain_write <= 1'b0;
			write_data <= '0;
			gain_quarters <= 3'h4;
		end else begin
			// R1: route by select bits
			input_write <= take && !pd_eff && select == SEL_INPUT;
			offset_write <= take && !pd_eff && select == SEL_OFFSET;
			gain_write <= take && !pd_eff && select == SEL_GAIN;
			if (take && !pd_eff && select != SEL_SPECIAL) begin
				write_data <= cmd_data;
			end
			if (take && !pd_eff && select == SEL_GAIN) begin
				gain_quarters <= gain_to_quarters(cmd_data);
			end
		end
	end

	// Clear and zero loads of all DAC registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clear_prev_reg <= 1'b0;
			dac_clear_load <= 1'b0;
			dac_zero_load <= 1'b0;
		end else begin
			clear_prev_reg <= clear_low_reg;
			// R5: pin or soft clear
			dac_clear_load <= (clear_low_reg && !clear_prev_reg)
				|| (special && !read_not_write && command_address_bits == CMD_SOFT_CLEAR);
			// R11: zero the DAC registers
			dac_zero_load <= special && !pd_eff && !read_not_write && command_address_bits == CMD_SOFT_RESET;
		end
	end

	// Readback of the control register; a no-op shifts out the last value.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			readback_data <= '0;
			readback_valid <= 1'b0;
		end else begin
			readback_valid <= 1'b0;
			// R13: control read
			if (special && read_not_write && command_address_bits == CMD_CONTROL) begin
				readback_data <= control_reg;
				readback_valid <= 1'b1;
			end else if (special && command_address_bits == CMD_NOP) begin
				// R3: no-op clocks out readback
				readback_valid <= 1'b1;
			end
		end
	end

	// ====================================================
	// Analog control outputs, all registered.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_down <= 1'b0;
			amplifiers_on <= 1'b0;
			power_down_output_state <= 1'b1;
			reference_level_select <= REF_LEVEL_DEFAULT;
			amplifier_boost <= 1'b0;
			internal_reference_enable <= 1'b0;
			monitor_enable <= 1'b0;
			thermal_guard_enable <= 1'b0;
			clear_code <= CLEAR_CODE_RESET;
			monitor_channel <= MON_OFF_CHANNEL;
			monitor_tristate <= 1'b1;
		end else begin
			power_down <= pd_eff;
			amplifiers_on <= !pd_eff && !thermal_trip_reg;
			// R14: power-down load
			power_down_output_state <= control_reg[CTL_PD_STATE];
			// R15: reference level
			reference_level_select <= control_reg[CTL_REF_LEVEL];
			// R16: boost enable
			amplifier_boost <= control_reg[CTL_BOOST];
			// R17: reference source
			internal_reference_enable <= control_reg[CTL_INT_REF];
			// R18: monitor on last channel
			monitor_enable <= control_reg[CTL_MONITOR];
			thermal_guard_enable <= control_reg[CTL_THERMAL];
			clear_code <= clear_code_reg;
			monitor_channel <= monitor_reg;
			// R23: channel 63 three-states
			monitor_tristate <= !control_reg[CTL_MONITOR] || monitor_reg == MON_OFF_CHANNEL;
		end
	end

	// Toggle enables expanded per channel; bits 7, 1 and 0 reach only the readback.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			toggle_enable <= '0;
		end else begin
			// R21: toggle group enable
			for (int ch = 0; ch < CHANNELS; ch++) begin
				// R22: eight channels per bit
				toggle_enable[ch] <= control_reg[CTL_TOGGLE_LO + (ch / GROUP_SIZE) % TOGGLE_GROUPS];
			end
		end
	end
	// R20: ignored bits unused
endmodule

// *** logic/sfr_decoder_pkg.sv ***
/*
 * Constants shared by the special-function command decoder: register-select
 * codes, command addresses, control register layout and timing figures.
 * Assumes a 25 MHz interface clock.
 */
package sfr_decoder_pkg;
	// ====================================================
	// Register select codes (high bit, low bit).
	localparam logic [1:0] SEL_INPUT = 2'h3;
	localparam logic [1:0] SEL_OFFSET = 2'h2;
	localparam logic [1:0] SEL_GAIN = 2'h1;
	localparam logic [1:0] SEL_SPECIAL = 2'h0;
	// ====================================================
	// Special function command addresses.
	localparam logic [5:0] CMD_NOP = 6'h00;
	localparam logic [5:0] CMD_CLEAR_CODE = 6'h01;
	localparam logic [5:0] CMD_SOFT_CLEAR = 6'h02;
	localparam logic [5:0] CMD_POWER_DOWN = 6'h08;
	localparam logic [5:0] CMD_POWER_UP = 6'h09;
	localparam logic [5:0] CMD_MONITOR = 6'h0a;
	localparam logic [5:0] CMD_CONTROL = 6'h0c;
	localparam logic [5:0] CMD_SOFT_RESET = 6'h0f;
	// ====================================================
	// Control register field positions and values.
	localparam int CTL_PD_STATE = 13;
	localparam int CTL_REF_LEVEL = 12;
	localparam int CTL_BOOST = 11;
	localparam int CTL_INT_REF = 10;
	localparam int CTL_MONITOR = 9;
	localparam int CTL_THERMAL = 8;
	localparam int CTL_TOGGLE_LO = 2;
	localparam int TOGGLE_GROUPS = 5;
	localparam int GROUP_SIZE = 8;
	localparam int MON_LO = 8;
	localparam logic [5:0] MON_OFF_CHANNEL = 6'h3f;
	localparam logic [13:0] CONTROL_RESET = 14'h2000;
	localparam logic [13:0] CLEAR_CODE_RESET = 14'h0000;
	// Gain codes whose low four bits mark a scaled full-scale entry.
	localparam logic [3:0] GAIN_TAIL = 4'he;
	localparam logic [9:0] GAIN_MIDDLE = 10'h3ff;
	// ====================================================
	// Timing, in nanoseconds, and the clock period.
	localparam int CLOCK_NS = 40;
	localparam int SOFT_CLEAR_NS = 35000;
	localparam int SOFT_RESET_NS = 135000;
	localparam int POWER_UP_NS = 8000;
	// Busy lengths; all times round down.
	localparam int SOFT_CLEAR_CYCLES = SOFT_CLEAR_NS / CLOCK_NS;
	localparam int SOFT_RESET_CYCLES = SOFT_RESET_NS / CLOCK_NS;
	localparam int POWER_UP_CYCLES = POWER_UP_NS / CLOCK_NS;
endpackage

// *** tb/host_model.sv ***
/* Host controller model: issues one decoded word per call.
   Assumes the decoder samples words on the rising clock edge. */
`timescale 1ns/100ps
module host_model (
	// Clock and status.
	input wire logic clock,
	input wire logic busy_n,
	// Decoded host word.
	output logic cmd_valid,
	output logic register_select_high,
	output logic register_select_low,
	output logic read_not_write,
	output logic [5:0] command_address_bits,
	output logic [13:0] cmd_data
);
	// Idle bus at time zero.
	initial begin
		cmd_valid = 1'b0;
		{register_select_high, register_select_low, read_not_write} = 3'h0;
		command_address_bits = 6'h00;
		cmd_data = 14'h0000;
	end
	// One word; waits out busy, so words never arrive closer than allowed.
	task automatic send(input logic [1:0] sel, input logic rd, input logic [5:0] a, input logic [13:0] d);
		int n;
		n = 0;
		@(posedge clock);
		while (busy_n !== 1'b1 && n < 5000) begin
			@(posedge clock);
			n++;
		end
		#1;
		{register_select_high, register_select_low} = sel;
		read_not_write = rd;
		command_address_bits = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge clock);
		#1;
		cmd_valid = 1'b0;
		// Stale data and address lines are inverted so nothing can lean on old values.
		cmd_data = ~d;
		command_address_bits = ~a;
		repeat (3) @(posedge clock);
		while (busy_n !== 1'b1 && n < 5000) begin
			@(posedge clock);
			n++;
		end
		#1;
	endtask
endmodule

// *** tb/sfr_decoder_assertions.sv ***
/* Port checker for the command decoder.
   Bound to the decoder; sees only its ports. */
`timescale 1ns/100ps
module sfr_decoder_assertions
	import sfr_decoder_pkg::*;
#(
	parameter int SOFT_CLEAR_LEN = 875,
	parameter int SOFT_RESET_LEN = 3375
) (
	// Clock, reset and word.
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic register_select_high,
	input wire logic register_select_low,
	input wire logic read_not_write,
	input wire logic [5:0] command_address_bits,
	input wire logic [13:0] cmd_data,
	// Outputs watched.
	input wire logic busy_n,
	input wire logic [13:0] readback_data,
	input wire logic readback_valid,
	input wire logic input_write,
	input wire logic [13:0] write_data,
	input wire logic dac_clear_load,
	input wire logic dac_zero_load,
	input wire logic power_down,
	input wire logic amplifiers_on,
	input wire logic power_down_output_state,
	input wire logic reference_level_select,
	input wire logic amplifier_boost,
	input wire logic internal_reference_enable,
	input wire logic monitor_enable,
	input wire logic thermal_guard_enable,
	input wire logic [39:0] toggle_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A command word that the idle decoder accepts.
	logic take;
	logic [5:0] a;
	logic [5:0] ctl6;
	logic [4:0] tog5;
	int busy_run; // Cycles busy_n has been low in the current run.
	logic [5:0] last_cmd; // Last accepted write command; reads count as no-op.
	assign take = cmd_valid && busy_n && !register_select_high && !register_select_low;
	assign a = command_address_bits;
	assign ctl6 = {power_down_output_state, reference_level_select, amplifier_boost,
		internal_reference_enable, monitor_enable, thermal_guard_enable};
	assign tog5 = {toggle_enable[32], toggle_enable[24], toggle_enable[16], toggle_enable[8], toggle_enable[0]};
	// Busy lengths are counted here, since long fixed delays are too costly.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_run <= 0;
			last_cmd <= CMD_NOP;
		end else begin
			busy_run <= busy_n ? 0 : busy_run + 1;
			if (take) begin
				last_cmd <= read_not_write ? CMD_NOP : a;
			end
		end
	end
	// ====================================================
	// Assertions.
	a_nop_busy_pulse: assert property (take && a == CMD_NOP |=> !busy_n && readback_valid ##1 busy_n)
		else $error("no-op busy pulse wrong");
	a_soft_clear_load: assert property (take && !read_not_write && a == CMD_SOFT_CLEAR |=> dac_clear_load && !busy_n)
		else $error("soft clear load wrong");
	a_clear_busy_len: assert property ($rose(busy_n) && last_cmd == CMD_SOFT_CLEAR
		|-> busy_run == SOFT_CLEAR_LEN)
		else $error("soft clear busy length wrong");
	a_soft_reset_run: assert property (take && !read_not_write && a == CMD_SOFT_RESET && !power_down
		|=> dac_zero_load && !busy_n)
		else $error("soft reset run wrong");
	a_reset_busy_len: assert property ($rose(busy_n) && last_cmd == CMD_SOFT_RESET
		|-> busy_run == SOFT_RESET_LEN)
		else $error("soft reset busy length wrong");
	a_ctl_write_fields: assert property (take && a == CMD_CONTROL && !read_not_write && !power_down
		|-> ##2 ctl6 == $past(cmd_data[13:8], 2) && tog5 == $past(cmd_data[6:2], 2))
		else $error("control write fields wrong");
	a_ctl_read_back: assert property (take && a == CMD_CONTROL && read_not_write
		|=> readback_valid && readback_data[13:8] == ctl6 && readback_data[6:2] == tog5)
		else $error("control readback wrong");
	a_pd_blocks_write: assert property (power_down && cmd_valid && register_select_high |=> !input_write)
		else $error("write passed in power-down");
	a_route_input: assert property (cmd_valid && busy_n && !power_down && register_select_high
		&& register_select_low |=> input_write && write_data == $past(cmd_data))
		else $error("input word not routed");
	a_undef_noop: assert property (take && a == 6'h3e
		|=> !dac_clear_load && !dac_zero_load && !readback_valid ##1 $stable(ctl6))
		else $error("undefined command acted");
	a_amp_off_pd: assert property (power_down && $past(power_down) |-> !amplifiers_on)
		else $error("amplifiers on in power-down");
	// Main scenarios reached.
	c_soft_clear: cover property (take && a == CMD_SOFT_CLEAR);
	c_soft_reset: cover property (take && a == CMD_SOFT_RESET);
	c_ctl_read: cover property (take && a == CMD_CONTROL && read_not_write);
endmodule
bind dac_special_function_decoder sfr_decoder_assertions #(.SOFT_CLEAR_LEN(SOFT_CLEAR_LEN),
	.SOFT_RESET_LEN(SOFT_RESET_LEN)) chk (.*);

// *** tb/tb_top.sv ***
/* Self-checking bench for the command decoder.
   Assumes host_model drives words; short busy lengths set below. */
`timescale 1ns/100ps
module tb_top;
	import sfr_decoder_pkg::*;
	localparam int CLR_LEN = 8;
	localparam int RST_LEN = 12;
	localparam int PU_LEN = 6;
	logic clock, rst_n, clear_pin_n, hw_power_down, over_temperature;
	logic cmd_valid, register_select_high, register_select_low, read_not_write;
	logic [5:0] command_address_bits, monitor_channel;
	logic [13:0] cmd_data, readback_data, write_data, clear_code;
	logic busy_n, readback_valid, input_write, offset_write, gain_write, dac_clear_load, dac_zero_load;
	logic power_down, amplifiers_on, power_down_output_state, reference_level_select, amplifier_boost;
	logic internal_reference_enable, monitor_enable, thermal_guard_enable, monitor_tristate;
	logic [2:0] gain_quarters;
	logic [39:0] toggle_enable;
	logic [5:0] ctl6;
	logic [31:0] lfsr = 32'h3765;
	int bad_count, checks, low_run, last_low, clr_seen, zero_seen, s;
	logic [13:0] d;
	logic [2:0] strobes; // Last routed write strobes seen: input, offset, gain.
	logic [13:0] gains [6] = '{14'h3ffe, 14'h2ffe, 14'h1ffe, 14'h0ffe, 14'h0000, 14'h1ff6};
	assign ctl6 = {power_down_output_state, reference_level_select, amplifier_boost,
		internal_reference_enable, monitor_enable, thermal_guard_enable};
	dac_special_function_decoder #(.SOFT_CLEAR_LEN(CLR_LEN), .SOFT_RESET_LEN(RST_LEN),
		.POWER_UP_LEN(PU_LEN)) DUT (.*);
	host_model host (.*);
	// 25 MHz clock.
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Busy-low run length and load pulses, seen at each edge.
	always @(posedge clock) begin
		if (busy_n === 1'b0) low_run++;
		else if (low_run != 0) begin
			last_low = low_run;
			low_run = 0;
		end
		if (dac_clear_load === 1'b1) clr_seen++;
		if (dac_zero_load === 1'b1) zero_seen++;
		if ({input_write, offset_write, gain_write} != 3'h0) strobes = {input_write, offset_write, gain_write};
	end
	function automatic logic [13:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[13:0];
	endfunction
	function automatic logic [39:0] exp_toggle(input logic [13:0] v);
		logic [39:0] t;
		for (int g = 0; g < 5; g++) t[g*8 +: 8] = {8{v[2+g]}};
		return t;
	endfunction
	function automatic logic [2:0] exp_gain(input logic [13:0] v);
		return (v[11:0] == 12'hffe) ? {1'b0, v[13:12]} + 3'd1 : 3'd0;
	endfunction
	task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic w(input logic [5:0] a, input logic [13:0] v);
		host.send(2'b00, 1'b0, a, v);
	endtask
	task automatic check_defaults();
		check("defaults", {ctl6, clear_code, monitor_channel, monitor_tristate, toggle_enable[0], power_down},
			{6'h30, 14'h0000, 6'h3f, 1'b1, 1'b0, 1'b0});
	endtask
	task automatic stop_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Watchdog: the whole run needs well under 3000 cycles.
	initial begin
		#(40 * 20000);
		bad_count++;
		stop_test();
	end
	// ====================================================
	// Main sequence.
	initial begin
		{rst_n, hw_power_down, over_temperature} = 3'b000;
		clear_pin_n = 1'b1;
		repeat (20) @(posedge clock);
		#1 rst_n = 1'b1;
		check_defaults();
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			d = (i == 0) ? 14'h3fff : rnd();
			w(CMD_CONTROL, d);
			w(CMD_CONTROL, d ^ 14'h0083);
			check("ctl", {ctl6, toggle_enable}, {d[13:8], exp_toggle(d)});
			host.send(2'b00, 1'b1, CMD_CONTROL, rnd());
			check("readback", {readback_data[13:8], readback_data[6:2]}, {d[13:8], d[6:2]});
		end
		$display("test control done");
		d = rnd();
		w(CMD_CLEAR_CODE, d);
		check("clear_code", clear_code, d);
		s = clr_seen;
		w(CMD_SOFT_CLEAR, rnd());
		check("soft_clear", {8'(clr_seen - s), last_low}, {8'h01, CLR_LEN});
		s = clr_seen;
		clear_pin_n = 1'b0;
		repeat (8) @(posedge clock);
		#1 clear_pin_n = 1'b1;
		check("clear_pin", clr_seen - s, 1);
		last_low = 0;
		w(CMD_NOP, rnd());
		check("nop_busy", last_low, 1);
		s = ctl6;
		last_low = 0;
		w(6'h3e, rnd());
		check("undefined", {20'(last_low), ctl6, clear_code}, {20'h00001, s[5:0], d});
		$display("test clear done");
		// The monitor is enabled before a channel is chosen.
		w(CMD_CONTROL, 14'h0200);
		s = rnd() % 40;
		d = rnd();
		w(CMD_MONITOR, {s[5:0], d[7:0]});
		check("monitor", {monitor_enable, monitor_channel, monitor_tristate}, {1'b1, s[5:0], 1'b0});
		w(CMD_MONITOR, 14'h3f00);
		check("mon_off", monitor_tristate, 1);
		foreach (gains[i]) begin
			host.send(2'b01, 1'b0, 6'h00, gains[i]);
			check("gain", {gain_quarters, write_data}, {exp_gain(gains[i]), gains[i]});
		end
		for (int k = 1; k < 4; k++) begin
			d = rnd();
			strobes = 3'h0;
			host.send(k[1:0], 1'b0, 6'h00, d);
			check("route", {strobes, write_data}, {3'(1 << (k - 1)), d});
		end
		$display("test monitor and gain done");
		w(CMD_POWER_DOWN, rnd());
		check("pd", {power_down, amplifiers_on}, 2'b10);
		s = ctl6;
		d = clear_code;
		w(CMD_CONTROL, ~{s[5:0], 8'h00});
		w(CMD_CLEAR_CODE, ~d);
		check("pd_block", {ctl6, clear_code}, {s[5:0], d});
		// A routed input word must also be dropped while powered down.
		strobes = 3'h0;
		d = write_data;
		host.send(2'b11, 1'b0, 6'h00, ~d);
		check("pd_route", {strobes, write_data}, {3'h0, d});
		w(CMD_POWER_UP, rnd());
		check("pu", {power_down, last_low}, {1'b0, PU_LEN});
		hw_power_down = 1'b1;
		repeat (6) @(posedge clock);
		#1 check("hw_pd", power_down, 1);
		hw_power_down = 1'b0;
		// Let the release pass the pin filter before the next write.
		repeat (6) @(posedge clock);
		w(CMD_CONTROL, 14'h0100);
		over_temperature = 1'b1;
		repeat (6) @(posedge clock);
		#1 check("hot", amplifiers_on, 0);
		over_temperature = 1'b0;
		repeat (6) @(posedge clock);
		w(CMD_POWER_UP, 14'h0000);
		check("cool", amplifiers_on, 1);
		$display("test power done");
		s = zero_seen;
		w(CMD_SOFT_RESET, rnd());
		check("soft_reset", {8'(zero_seen - s), last_low}, {8'h01, RST_LEN});
		check_defaults();
		$display("test soft reset done");
		stop_test();
	end
endmodule
